// ==== rtl/sfrp_pkg.sv ====
// Shared constants and carrier types of the serial flash read path.
package sfrp_pkg;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_ENABLE      = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE     = 8'h04;
    localparam logic [7:0] CMD_WRITE_VOL_PATTERN = 8'h4A;
    localparam logic [7:0] CMD_PATTERN_READ      = 8'h41;
    localparam logic [7:0] CMD_PLAIN_READ        = 8'h03;
    localparam logic [7:0] CMD_PLAIN_READ_WIDE   = 8'h13;
    localparam logic [7:0] CMD_QUICK_READ        = 8'h0B;
    localparam logic [7:0] CMD_QUICK_READ_WIDE   = 8'h0C;
    localparam logic [7:0] CMD_QUAD_IO_READ      = 8'hEB;
    localparam logic [7:0] CMD_QUAD_IO_READ_WIDE = 8'hEC;

    // ------------------------------------------------------------------
    // Field sizes and counts
    // ------------------------------------------------------------------
    localparam int          BYTE_BITS         = 8;
    localparam int          SHORT_ADDR_BITS   = 24;
    localparam int          WIDE_ADDR_BITS    = 32;
    localparam int          QUAD_MODE_CYCLES  = 2;
    localparam logic [3:0]  CONT_READ_NIBBLE  = 4'hA;
    localparam logic [1:0]  LC_NO_DUMMY       = 2'h3;
    localparam logic [3:0]  FAST_DUMMY_CYCLES = 4'h8;
    localparam logic [3:0]  QUAD_DUMMY_CYCLES = 4'h4;
    localparam logic [7:0]  PATTERN_RESET     = 8'h00;
    localparam logic [7:0]  BANK_RESET        = 8'h00;
    localparam int          BANK_EXT_BIT      = 7;

    // ------------------------------------------------------------------
    // Sequencer states, Gray coded along the usual path
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SFRP_IDLE   = 3'b000,
        SFRP_OPCODE = 3'b001,
        SFRP_ADDR   = 3'b011,
        SFRP_MODE   = 3'b010,
        SFRP_DUMMY  = 3'b110,
        SFRP_DATA   = 3'b111,
        SFRP_WDATA  = 3'b101,
        SFRP_HOLD   = 3'b100
    } sfrp_state_type;

    // Array read request and answer carried between core and array.
    typedef struct packed {
        logic [31:0] addr;
    } sfrp_req_type;

    typedef struct packed {
        logic [7:0] data;
    } sfrp_word_type;

endpackage

// ==== rtl/sfrp_skid_buffer.sv ====
// Two-entry valid/ready buffer in the array read data path.
`timescale 1ns/1ps
module sfrp_skid_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [PW:0]                 count;
        logic                        full;
    } sfrp_buf_type;

    sfrp_buf_type buf_reg;
    sfrp_buf_type buf_next;
    logic         push;
    logic         pop;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        buf_next = buf_reg;
        push = in_valid_i && (buf_reg.count != (PW+1)'(DEPTH));
        pop  = out_ready_i && (buf_reg.count != '0);
        if (push) begin
            buf_next.mem[buf_reg.wr] = in_data_i;
            buf_next.wr = (buf_reg.wr == PW'(DEPTH - 1)) ? '0 : buf_reg.wr + 1'b1;
        end
        if (pop) begin
            buf_next.rd = (buf_reg.rd == PW'(DEPTH - 1)) ? '0 : buf_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            buf_next.count = buf_reg.count + 1'b1;
        end else if (pop && !push) begin
            buf_next.count = buf_reg.count - 1'b1;
        end
        if (flush_i) begin
            buf_next.wr = '0;
            buf_next.rd = '0;
            buf_next.count = '0;
        end
        buf_next.full = (buf_next.count == (PW+1)'(DEPTH));
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            buf_reg <= '0;
        end else begin
            buf_reg <= buf_next;
        end
    end

    assign in_ready_o  = !buf_reg.full;
    assign out_valid_o = (buf_reg.count != '0);
    assign out_data_o  = buf_reg.mem[buf_reg.rd];

endmodule

// ==== rtl/sfrp_read_path.sv ====
// Flash-side command sequencer for pattern register and array read commands.
`timescale 1ns/1ps

// Summary of operation
// - Pattern write needs write enable latch set.
// - Pattern write: opcode, one byte, then select.
// - Select rise after write updates register immediately.
// - Pattern read shifts out eight pattern bits.
// - Pattern repeats every eight clocks while clocked.
// - Read starts with opcode then 3/4 address.
// - Short addresses take upper bits from bank.
// - Extended bit forces four address bytes except in small variant.
// - Small variant ignores bits above A23.
// - Latency code 3 skips fast read dummies.
// - Dummies counted falling to falling edge.
// - Output data changes on falling clock.
// - Last four dummies carry pattern bits 7, 5, 3, 1.
// - Select rise ends read at once.
// - Plain read 03h/13h, no dummy cycles.
// - Fast read 0Bh follows mode, 0Ch wide.
// - Fast read inserts zero or eight dummies.
// - Address increments per byte and wraps.
// - Quad reads sample mode bits after address.
// - Mode nibble A keeps continuous read state.
module sfrp_read_path #(
    parameter int  ARRAY_ADDR_BITS = 25,
    parameter bit  SMALL_DENSITY   = 1'b0
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      sck_i,
    input  wire logic                      cs_n_i,
    input  wire logic [3:0]                io_i,
    output logic      [3:0]                io_o,
    output logic      [3:0]                io_oe_o,
    input  wire logic [1:0]                latency_code_i,
    input  wire logic                      pattern_in_dummy_i,
    input  wire logic [7:0]                bank_wr_data_i,
    input  wire logic                      bank_wr_i,
    output logic      [7:0]                bank_o,
    output logic      [7:0]                volatile_pattern_o,
    output logic                           write_enable_latch_o,
    output logic                           continuous_read_o,
    output logic                           array_req_valid_o,
    output sfrp_pkg::sfrp_req_type         array_req_o,
    input  wire logic                      array_rsp_valid_i,
    output logic                           array_rsp_ready_o,
    input  wire sfrp_pkg::sfrp_word_type   array_rsp_i
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                  sck_sync;
        logic                        sck_last;
        logic [1:0]                  cs_sync;
        logic                        cs_last;
        logic [1:0][3:0]             io_sync;
        sfrp_pkg::sfrp_state_type    state;
        logic [7:0]                  opcode;
        logic [31:0]                 shift;
        logic [5:0]                  bits;
        logic [5:0]                  addr_bits;
        logic                        quad;
        logic [3:0]                  dummy_left;
        logic [31:0]                 addr;
        logic [7:0]                  out_byte;
        logic [3:0]                  out_bit;
        logic                        out_pattern;
        logic                        req_pending;
        logic                        cont;
        logic                        cont_next_frame;
        logic                        write_enable_latch;
        logic [7:0]                  pattern;
        logic [7:0]                  bank;
        logic [3:0]                  io_out;
        logic [3:0]                  io_oe;
    } sfrp_core_type;

    sfrp_core_type r_reg;
    sfrp_core_type r_next;

    logic                    sck_rise;
    logic                    sck_fall;
    logic                    cs_rise;
    logic                    cs_fall;
    logic                    cs_low;
    logic [3:0]              io_s;
    logic                    buf_out_valid;
    logic                    buf_pop;
    logic                    buf_flush;
    sfrp_pkg::sfrp_word_type buf_out;

    // Upper address from bank for short commands; small parts drop it.
    function automatic logic [31:0] form_addr(input logic [31:0] raw,
                                              input logic [5:0]  nbits,
                                              input logic [7:0]  bank);
        logic [31:0] a;
        a = (nbits == 6'(sfrp_pkg::SHORT_ADDR_BITS)) ? {1'b0, bank[6:0], raw[23:0]} : raw;
        a = {1'b0, a[31:1]} << 1 | {31'h0000_0000, a[0]};
        if (SMALL_DENSITY) begin
            a = {8'h00, a[23:0]};
        end
        return a & ((32'h0000_0001 << ARRAY_ADDR_BITS) - 32'h0000_0001);
    endfunction

    // Instruction decode: address length, zero if not an address command.
    function automatic logic [5:0] addr_len(input logic [7:0] op, input logic ext);
        case (op)
            sfrp_pkg::CMD_PLAIN_READ, sfrp_pkg::CMD_QUICK_READ,
            sfrp_pkg::CMD_QUAD_IO_READ:
                addr_len = ext ? 6'(sfrp_pkg::WIDE_ADDR_BITS)
                               : 6'(sfrp_pkg::SHORT_ADDR_BITS);
            sfrp_pkg::CMD_PLAIN_READ_WIDE, sfrp_pkg::CMD_QUICK_READ_WIDE,
            sfrp_pkg::CMD_QUAD_IO_READ_WIDE:
                addr_len = 6'(sfrp_pkg::WIDE_ADDR_BITS);
            default:
                addr_len = 6'd0;
        endcase
    endfunction

    assign sck_rise = r_reg.sck_sync[1] && !r_reg.sck_last;
    assign sck_fall = !r_reg.sck_sync[1] && r_reg.sck_last;
    assign cs_rise  = r_reg.cs_sync[1] && !r_reg.cs_last;
    assign cs_fall  = !r_reg.cs_sync[1] && r_reg.cs_last;
    assign cs_low   = !r_reg.cs_sync[1];
    assign io_s     = r_reg.io_sync[1];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic ext;
        ext = r_reg.bank[sfrp_pkg::BANK_EXT_BIT] && !SMALL_DENSITY;
        r_next = r_reg;
        buf_pop = 1'b0;
        buf_flush = 1'b0;
        r_next.sck_sync = {r_reg.sck_sync[0], sck_i};
        r_next.cs_sync  = {r_reg.cs_sync[0], cs_n_i};
        r_next.io_sync  = {r_reg.io_sync[0], io_i};
        r_next.sck_last = r_reg.sck_sync[1];
        r_next.cs_last  = r_reg.cs_sync[1];
        if (bank_wr_i) begin
            r_next.bank = bank_wr_data_i;
        end
        if (r_reg.req_pending) begin
            r_next.req_pending = 1'b0;
        end
        if (cs_fall) begin
            r_next.bits = '0;
            r_next.shift = '0;
            r_next.quad = r_reg.cont;
            r_next.addr_bits = r_reg.cont ? addr_len(sfrp_pkg::CMD_QUAD_IO_READ, ext) : 6'd0;
            r_next.state = r_reg.cont ? sfrp_pkg::SFRP_ADDR : sfrp_pkg::SFRP_OPCODE;
            r_next.opcode = r_reg.cont ? sfrp_pkg::CMD_QUAD_IO_READ : 8'h00;
        end else if (cs_rise) begin
            r_next.state = sfrp_pkg::SFRP_IDLE;
            r_next.io_oe = 4'h0;
            buf_flush = 1'b1;
            if (r_reg.state == sfrp_pkg::SFRP_HOLD) begin
                if (r_reg.opcode == sfrp_pkg::CMD_WRITE_ENABLE) begin
                    r_next.write_enable_latch = 1'b1;
                end else if (r_reg.opcode == sfrp_pkg::CMD_WRITE_DISABLE) begin
                    r_next.write_enable_latch = 1'b0;
                end else if (r_reg.opcode == sfrp_pkg::CMD_WRITE_VOL_PATTERN
                             && r_reg.write_enable_latch) begin
                    r_next.pattern = r_reg.shift[7:0];
                end
            end
            if (r_reg.quad && r_reg.state == sfrp_pkg::SFRP_DATA) begin
                r_next.cont = r_reg.cont_next_frame;
            end else if (r_reg.state != sfrp_pkg::SFRP_IDLE) begin
                r_next.cont = 1'b0;
            end
        end else if (cs_low && sck_rise) begin
            case (r_reg.state)
                sfrp_pkg::SFRP_OPCODE: begin
                    r_next.shift = {r_reg.shift[30:0], io_s[0]};
                    r_next.bits = r_reg.bits + 6'd1;
                    if (r_reg.bits == 6'(sfrp_pkg::BYTE_BITS - 1)) begin
                        r_next.opcode = {r_reg.shift[6:0], io_s[0]};
                        r_next.bits = '0;
                        r_next.addr_bits = addr_len({r_reg.shift[6:0], io_s[0]}, ext);
                        r_next.quad = (r_next.opcode == sfrp_pkg::CMD_QUAD_IO_READ)
                                      || (r_next.opcode == sfrp_pkg::CMD_QUAD_IO_READ_WIDE);
                        if (addr_len({r_reg.shift[6:0], io_s[0]}, ext) != 6'd0) begin
                            r_next.state = sfrp_pkg::SFRP_ADDR;
                        end else if ({r_reg.shift[6:0], io_s[0]}
                                     == sfrp_pkg::CMD_WRITE_VOL_PATTERN) begin
                            r_next.state = sfrp_pkg::SFRP_WDATA;
                        end else if ({r_reg.shift[6:0], io_s[0]}
                                     == sfrp_pkg::CMD_PATTERN_READ) begin
                            r_next.state = sfrp_pkg::SFRP_DATA;
                            r_next.out_pattern = 1'b1;
                            r_next.out_byte = r_reg.pattern;
                            r_next.out_bit = 4'd0;
                        end else begin
                            r_next.state = sfrp_pkg::SFRP_HOLD;
                        end
                    end
                end
                sfrp_pkg::SFRP_WDATA: begin
                    r_next.shift = {r_reg.shift[30:0], io_s[0]};
                    r_next.bits = r_reg.bits + 6'd1;
                    if (r_reg.bits == 6'(sfrp_pkg::BYTE_BITS - 1)) begin
                        r_next.state = sfrp_pkg::SFRP_HOLD;
                    end
                end
                sfrp_pkg::SFRP_ADDR: begin
                    if (r_reg.quad) begin
                        r_next.shift = {r_reg.shift[27:0], io_s};
                        r_next.bits = r_reg.bits + 6'd4;
                    end else begin
                        r_next.shift = {r_reg.shift[30:0], io_s[0]};
                        r_next.bits = r_reg.bits + 6'd1;
                    end
                    if (r_next.bits == r_reg.addr_bits) begin
                        r_next.addr = form_addr(r_next.shift, r_reg.addr_bits, r_reg.bank);
                        r_next.req_pending = 1'b1;
                        r_next.bits = '0;
                        r_next.out_pattern = 1'b0;
                        if (r_reg.quad) begin
                            r_next.state = sfrp_pkg::SFRP_MODE;
                        end else if (r_reg.opcode == sfrp_pkg::CMD_PLAIN_READ
                                     || r_reg.opcode == sfrp_pkg::CMD_PLAIN_READ_WIDE
                                     || latency_code_i == sfrp_pkg::LC_NO_DUMMY) begin
                            r_next.state = sfrp_pkg::SFRP_DATA;
                            r_next.out_bit = 4'd8;
                        end else begin
                            r_next.state = sfrp_pkg::SFRP_DUMMY;
                            r_next.dummy_left = sfrp_pkg::FAST_DUMMY_CYCLES;
                        end
                    end
                end
                sfrp_pkg::SFRP_HOLD: begin
                    r_next.state = sfrp_pkg::SFRP_IDLE;
                end
                sfrp_pkg::SFRP_MODE: begin
                    r_next.bits = r_reg.bits + 6'd1;
                    if (r_reg.bits == 6'd0) begin
                        r_next.cont_next_frame = (io_s == sfrp_pkg::CONT_READ_NIBBLE);
                    end
                    if (r_reg.bits == 6'(sfrp_pkg::QUAD_MODE_CYCLES - 1)) begin
                        r_next.state = sfrp_pkg::SFRP_DUMMY;
                        r_next.dummy_left = sfrp_pkg::QUAD_DUMMY_CYCLES;
                    end
                end
                default: begin
                end
            endcase
        end else if (cs_low && sck_fall) begin
            case (r_reg.state)
                sfrp_pkg::SFRP_DUMMY: begin
                    r_next.dummy_left = r_reg.dummy_left - 4'd1;
                    if (pattern_in_dummy_i && r_reg.dummy_left <= 4'd4) begin
                        r_next.io_out = {4{r_reg.pattern[{r_reg.dummy_left[1:0] - 2'd1, 1'b1}]}};
                        r_next.io_oe = 4'hF;
                    end
                    if (r_reg.dummy_left == 4'd1) begin
                        r_next.state = sfrp_pkg::SFRP_DATA;
                        r_next.out_bit = 4'd8;
                    end
                end
                sfrp_pkg::SFRP_DATA: begin
                    if (r_reg.out_pattern) begin
                        r_next.io_out = {2'b00, r_reg.pattern[3'd7 - r_reg.out_bit[2:0]], 1'b0};
                        r_next.io_oe = 4'h2;
                        r_next.out_bit = {1'b0, r_reg.out_bit[2:0] + 3'd1};
                    end else begin
                        if (r_reg.out_bit >= (r_reg.quad ? 4'd8 : 4'd8)
                            && (r_reg.out_bit == 4'd8)) begin
                            r_next.out_byte = buf_out.data;
                            buf_pop = buf_out_valid;
                            r_next.out_bit = 4'd0;
                            r_next.addr = r_reg.addr + 32'h0000_0001;
                            if (r_next.addr[ARRAY_ADDR_BITS % 32] && ARRAY_ADDR_BITS < 32) begin
                                r_next.addr = 32'h0000_0000;
                            end
                            r_next.req_pending = 1'b1;
                        end
                        if (r_reg.quad) begin
                            r_next.io_out = (r_reg.out_bit == 4'd8) ? buf_out.data[7:4]
                                                                    : r_reg.out_byte[3:0];
                            r_next.io_oe = 4'hF;
                            r_next.out_bit = (r_reg.out_bit == 4'd8) ? 4'd4 : 4'd8;
                        end else begin
                            r_next.io_out = {2'b00,
                                (r_reg.out_bit == 4'd8) ? buf_out.data[7]
                                                        : r_reg.out_byte[3'd7 - r_reg.out_bit[2:0]],
                                1'b0};
                            r_next.io_oe = 4'h2;
                            r_next.out_bit = (r_reg.out_bit == 4'd8) ? 4'd1
                                           : (r_reg.out_bit == 4'd7) ? 4'd8
                                           : r_reg.out_bit + 4'd1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r_reg <= '{sck_sync: 2'b00, cs_sync: 2'b11, cs_last: 1'b1,
                       state: sfrp_pkg::SFRP_IDLE,
                       pattern: sfrp_pkg::PATTERN_RESET,
                       bank: sfrp_pkg::BANK_RESET, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Array data buffer
    // ------------------------------------------------------------------
    sfrp_skid_buffer #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_buffer (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .flush_i     (buf_flush),
        .in_valid_i  (array_rsp_valid_i),
        .in_ready_o  (array_rsp_ready_o),
        .in_data_i   (array_rsp_i.data),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_out.data)
    );

    assign io_o                 = r_reg.io_out;
    assign io_oe_o              = r_reg.io_oe;
    assign bank_o               = r_reg.bank;
    assign volatile_pattern_o   = r_reg.pattern;
    assign write_enable_latch_o = r_reg.write_enable_latch;
    assign continuous_read_o    = r_reg.cont;
    assign array_req_valid_o    = r_reg.req_pending;
    assign array_req_o.addr     = r_reg.addr;

endmodule

// ==== testbench/sfrp_props.sv ====
// Port checks of the serial flash read path.
`timescale 1ns/1ps
module sfrp_props #(
    parameter int ARRAY_ADDR_BITS = 25
) (
    input wire logic                   clk_i,
    input wire logic                   reset_i,
    input wire logic                   sck_i,
    input wire logic                   cs_n_i,
    input wire logic [3:0]             io_o,
    input wire logic [3:0]             io_oe_o,
    input wire logic [7:0]             bank_wr_data_i,
    input wire logic                   bank_wr_i,
    input wire logic [7:0]             bank_o,
    input wire logic [7:0]             volatile_pattern_o,
    input wire logic                   write_enable_latch_o,
    input wire logic                   array_req_valid_o,
    input wire sfrp_pkg::sfrp_req_type array_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_idle_oe; cs_n_i [*6] |-> io_oe_o == 4'h0; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("drive while idle");
    property p_fall; $changed(io_o) |-> !sck_i; endproperty
    a_fall: assert property (p_fall) else $error("data moved on high clock");
    property p_pat_wel; $changed(volatile_pattern_o) |-> $past(write_enable_latch_o); endproperty
    a_pat_wel: assert property (p_pat_wel) else $error("pattern without latch");
    property p_pat_cs; $changed(volatile_pattern_o) |-> cs_n_i; endproperty
    a_pat_cs: assert property (p_pat_cs) else $error("pattern moved in frame");
    property p_wel_cs; $changed(write_enable_latch_o) |-> cs_n_i; endproperty
    a_wel_cs: assert property (p_wel_cs) else $error("latch moved in frame");
    property p_bank_ld; bank_wr_i |=> bank_o == $past(bank_wr_data_i); endproperty
    a_bank_ld: assert property (p_bank_ld) else $error("bank not loaded");
    property p_bank_hold; !bank_wr_i |=> $stable(bank_o); endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank moved");
    property p_wrap; array_req_valid_o |-> (array_req_o.addr >> ARRAY_ADDR_BITS) == 0; endproperty
    a_wrap: assert property (p_wrap) else $error("address beyond array");
endmodule
bind sfrp_read_path sfrp_props #(.ARRAY_ADDR_BITS(ARRAY_ADDR_BITS)) u_props (.clk_i, .reset_i,
    .sck_i, .cs_n_i, .io_o, .io_oe_o, .bank_wr_data_i, .bank_wr_i, .bank_o, .volatile_pattern_o,
    .write_enable_latch_o, .array_req_valid_o, .array_req_o);

// ==== testbench/sfrp_host_model.sv ====
// Host controller model framing commands with select and a 200 ns serial clock.
`timescale 1ns/1ps
module sfrp_host_model (
    input  wire logic  clk_i,
    input  wire logic  so_i,
    output logic       sck_o = 1'b0,
    output logic       cs_n_o = 1'b1,
    output logic [3:0] io_o = 4'h0
);
    task automatic half();
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic xfer(input logic [63:0] tx, input int nt, input int nr, output logic [63:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        for (int i = 0; i < nt + nr; i++) begin
            io_o = {3'($urandom), (i < nt) ? tx[nt-1-i] : 1'($urandom)};
            half();
            sck_o = 1'b1;
            rx = {rx[62:0], so_i};
            half();
            sck_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        // Released lines flip so that stale levels never pass for data.
        io_o = ~io_o;
        repeat (4) half();
    endtask
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench with host model, array responder and expected values.
`timescale 1ns/1ps
module testbench;
    localparam int          AW = 25;
    localparam logic [31:0] MSK = (32'h1 << AW) - 1;
    logic                    clk_i = 1'b0, reset_i = 1'b1, bwr = 1'b0, pdum = 1'b0, rsp_v = 1'b0;
    logic                    sck, cs_n, req_v, rsp_rdy, write_enable_latch, cr;
    logic [3:0]              io_in, io_out, io_oe;
    logic [1:0]              lat = 2'h0;
    logic [7:0]              bd = 8'h00, bank, pat, ep, q[$];
    logic [31:0]             a, ea;
    logic [63:0]             rx;
    int                      bad_count = 0, n_compared = 0, na, nd;
    sfrp_pkg::sfrp_req_type  req;
    sfrp_pkg::sfrp_word_type rsp = '0;
    logic [7:0]              op_t[7] = '{8'h03, 8'h03, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'h0B};
    logic [7:0]              bk_t[7] = '{8'h00, 8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80};
    logic [1:0]              lc_t[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2};
    always #12.5 clk_i = ~clk_i;
    sfrp_read_path #(.ARRAY_ADDR_BITS(AW)) dut (.clk_i, .reset_i, .sck_i(sck), .cs_n_i(cs_n),
        .io_i(io_in), .io_o(io_out), .io_oe_o(io_oe), .latency_code_i(lat),
        .pattern_in_dummy_i(pdum), .bank_wr_data_i(bd), .bank_wr_i(bwr), .bank_o(bank),
        .volatile_pattern_o(pat), .write_enable_latch_o(write_enable_latch), .continuous_read_o(cr),
        .array_req_valid_o(req_v), .array_req_o(req), .array_rsp_valid_i(rsp_v),
        .array_rsp_ready_o(rsp_rdy), .array_rsp_i(rsp));
    sfrp_host_model host (.clk_i, .so_i(io_oe[1] ? io_out[1] : ~io_out[1]), .sck_o(sck),
        .cs_n_o(cs_n), .io_o(io_in));
    function automatic logic [7:0] mem(input logic [31:0] ad);
        return ad[7:0] ^ ad[15:8] ^ ad[23:16] ^ ad[31:24] ^ {ad[24], 7'h00};
    endfunction
    always @(posedge clk_i) begin
        if ($sampled(rsp_v) && $sampled(rsp_rdy))
            void'(q.pop_front());
        if ($sampled(req_v))
            q.push_back(mem($sampled(req.addr)));
        if (cs_n)
            q.delete();
        #1;
        rsp_v = q.size() > 0;
        rsp.data = (q.size() > 0) ? q[0] : 8'($urandom);
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #2_000_000;
        bad_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(8721));
        repeat (16) @(posedge clk_i);
        #1 reset_i = 1'b0;
        check("bank_reset", bank, 8'h00);
        ep = 8'($urandom) | 8'h01;
        host.xfer({8'h4A, ep}, 16, 0, rx);
        check("pattern_no_latch", pat, 8'h00);
        host.xfer(8'h06, 8, 0, rx);
        check("latch", write_enable_latch, 1'b1);
        host.xfer({8'h4A, ep, 1'b1}, 17, 0, rx);
        check("pattern_long", pat, 8'h00);
        host.xfer(8'h06, 8, 0, rx);
        host.xfer({8'h4A, ep}, 16, 0, rx);
        check("pattern", pat, ep);
        host.xfer(8'h41, 8, 16, rx);
        check("pattern_read", rx[15:0], {ep, ep});
        for (int k = 0; k < 7; k++) begin
            bd = bk_t[k];
            bwr = 1'b1;
            lat = lc_t[k];
            pdum = 1'($urandom);
            @(posedge clk_i);
            #1 bwr = 1'b0;
            check("bank", bank, bk_t[k]);
            a = (k == 3) ? 32'h01FF_FFFF : $urandom;
            na = (op_t[k] == 8'h13 || op_t[k] == 8'h0C || bk_t[k][7]) ? 4 : 3;
            nd = ((op_t[k] == 8'h0B || op_t[k] == 8'h0C) && lc_t[k] != 2'h3) ? 8 : 0;
            rx = (na == 4) ? {op_t[k], a} : {op_t[k], a[23:0]};
            host.xfer((rx << nd) | 64'($urandom & ((32'h1 << nd) - 1)), 8 + 8 * na + nd, 24, rx);
            ea = ((na == 4) ? a : {bk_t[k], a[23:0]}) & MSK;
            for (int i = 0; i < 3; i++)
                check("read_byte", rx[23-8*i -: 8], mem((ea + 32'(i)) & MSK));
        end
        check("cont_read", cr, 1'b0);
        give_verdict();
    end
endmodule
